// File: verilog/ahpc_pkg.sv
`default_nettype none
package ahpc_pkg;
  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W       = 10;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam logic [9:0]  MID_CODE     = 10'h200;
  localparam logic [9:0]  CODE_MAX     = 10'h3FF;
  localparam logic [9:0]  CODE_MIN     = 10'h001;
  localparam logic [9:0]  CODE_ZERO    = 10'h000;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CR0_CAL_HI   = 7;
  localparam int unsigned CR0_CAL_LO   = 6;
  localparam int unsigned CR0_APD_BIT  = 4;
  localparam int unsigned CR0_TRIG_BIT = 1;
  localparam int unsigned CR1_FMT_BIT  = 2;
  localparam int unsigned CR1_SPD_BIT  = 0;
  localparam logic [1:0]  CAL_NORMAL   = 2'h0;
  localparam logic [1:0]  CAL_SYSTEM   = 2'h1;
  localparam logic [1:0]  CAL_INTERNAL = 2'h2;
  localparam logic [1:0]  CAL_IDLE     = 2'h3;
  localparam logic [7:0]  CR_RESET     = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SPD_ENTER_NS  = 200;
  localparam int unsigned SPD_WAKE_NS   = 1000;
  localparam int unsigned APD_WAKE_NS   = 700;
  localparam int unsigned SPD_ENTER_CYC = SPD_ENTER_NS / CLK_PERIOD_NS;
  localparam int unsigned SPD_WAKE_CYC  = (SPD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned APD_WAKE_CYC  = (APD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 5;
  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AHPC_PWR_ON   = 4'h1,
    AHPC_PWR_AUTO = 4'h2,
    AHPC_PWR_SOFT = 4'h4,
    AHPC_PWR_WAKE = 4'h8
  } ahpc_pwr_e;
endpackage
`default_nettype wire

// File: verilog/ahpc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ahpc_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem[rd_ptr_r];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/ahpc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ahpc_ctrl (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  // Host strobes
  input  wire logic       cs_n_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic       conv_trigger_n_in,
  input  wire logic [9:0] data_in,
  // Host data bus and interrupt
  output logic      [9:0] data_out,
  output logic            data_oe_out,
  output logic            int_n_out,
  // Converter core
  input  wire logic       differential_in,
  input  wire logic [9:0] raw_code_in,
  input  wire logic       raw_valid_in,
  output logic            sample_start_out,
  output logic            short_to_mid_out,
  // Power and configuration status
  output logic            analog_on_out,
  output logic            ref_current_on_out,
  output logic            io_on_out,
  output logic            conv_ready_out,
  output logic      [7:0] control_reg_zero_out,
  output logic      [7:0] control_reg_one_out
);
  // ----------------------------------------------------------------
  // Strobe edges
  // ----------------------------------------------------------------
  logic cs_n_d_r;
  logic rd_n_d_r;
  logic wr_n_d_r;
  logic trig_n_d_r;
  logic int_n_d_r;
  logic rd_fall;
  logic rd_rise;
  logic cs_fall;
  logic cs_rise;
  logic wr_rise;
  logic trig_fall;
  logic int_fall;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cs_n_d_r   <= 1'b1;
      rd_n_d_r   <= 1'b1;
      wr_n_d_r   <= 1'b1;
      trig_n_d_r <= 1'b1;
      int_n_d_r  <= 1'b1;
    end else begin
      cs_n_d_r   <= cs_n_in;
      rd_n_d_r   <= rd_n_in;
      wr_n_d_r   <= wr_n_in;
      trig_n_d_r <= conv_trigger_n_in;
      int_n_d_r  <= int_n_out;
    end
  end

  assign rd_fall   = rd_n_d_r && !rd_n_in && !cs_n_in;
  assign rd_rise   = !rd_n_d_r && rd_n_in;
  assign cs_fall   = cs_n_d_r && !cs_n_in;
  assign cs_rise   = !cs_n_d_r && cs_n_in;
  assign wr_rise   = !wr_n_d_r && wr_n_in && !cs_n_in;
  assign trig_fall = trig_n_d_r && !conv_trigger_n_in;
  assign int_fall  = int_n_d_r && !int_n_out;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Bit 9 of the written word selects which register takes the low byte.
  logic [7:0] cr0_r;
  logic [7:0] cr1_r;
  logic [1:0] cal_field;
  logic       cal_mode;
  logic       apd_en;
  logic       trig_is_ext;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cr0_r <= ahpc_pkg::CR_RESET;
      cr1_r <= ahpc_pkg::CR_RESET;
    end else if (wr_rise) begin
      if (data_in[9]) begin
        cr1_r <= data_in[7:0];
      end else begin
        cr0_r <= data_in[7:0];
      end
    end
  end

  assign cal_field   = cr0_r[ahpc_pkg::CR0_CAL_HI:ahpc_pkg::CR0_CAL_LO];
  assign cal_mode    = (cal_field == ahpc_pkg::CAL_INTERNAL) ||
                       (cal_field == ahpc_pkg::CAL_SYSTEM);
  assign apd_en      = cr0_r[ahpc_pkg::CR0_APD_BIT];
  assign trig_is_ext = cr0_r[ahpc_pkg::CR0_TRIG_BIT];
  assign control_reg_zero_out = cr0_r;
  assign control_reg_one_out  = cr1_r;
  assign short_to_mid_out     = (cal_field == ahpc_pkg::CAL_INTERNAL);

  // ----------------------------------------------------------------
  // Power sequencing
  // ----------------------------------------------------------------
  ahpc_pkg::ahpc_pwr_e pwr_r;
  logic [ahpc_pkg::CNT_W-1:0] pwr_cnt_r;
  logic                       spd_arm_r;
  logic                       spd_req;

  assign spd_req = cr1_r[ahpc_pkg::CR1_SPD_BIT];

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      spd_arm_r <= 1'b0;
    end else if (!spd_req) begin
      spd_arm_r <= 1'b0;
    end else if (cs_rise) begin
      spd_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pwr_r     <= ahpc_pkg::AHPC_PWR_ON;
      pwr_cnt_r <= '0;
    end else begin
      case (pwr_r)
        ahpc_pkg::AHPC_PWR_ON: begin
          if (spd_arm_r && cs_n_in) begin
            if (pwr_cnt_r == ahpc_pkg::CNT_W'(ahpc_pkg::SPD_ENTER_CYC - 1)) begin
              pwr_r     <= ahpc_pkg::AHPC_PWR_SOFT;
              pwr_cnt_r <= '0;
            end else begin
              pwr_cnt_r <= pwr_cnt_r + 1'b1;
            end
          end else if (apd_en && int_fall) begin
            pwr_r     <= ahpc_pkg::AHPC_PWR_AUTO;
            pwr_cnt_r <= '0;
          end else begin
            pwr_cnt_r <= '0;
          end
        end
        ahpc_pkg::AHPC_PWR_AUTO: begin
          if (spd_arm_r) begin
            pwr_r <= ahpc_pkg::AHPC_PWR_SOFT;
          end else if ((!trig_is_ext && cs_fall) || (trig_is_ext && trig_fall)) begin
            pwr_r     <= ahpc_pkg::AHPC_PWR_WAKE;
            pwr_cnt_r <= ahpc_pkg::CNT_W'(ahpc_pkg::APD_WAKE_CYC);
          end
        end
        ahpc_pkg::AHPC_PWR_SOFT: begin
          if (!spd_req) begin
            pwr_r     <= ahpc_pkg::AHPC_PWR_WAKE;
            pwr_cnt_r <= ahpc_pkg::CNT_W'(ahpc_pkg::SPD_WAKE_CYC);
          end
        end
        ahpc_pkg::AHPC_PWR_WAKE: begin
          if (pwr_cnt_r == ahpc_pkg::CNT_W'(1)) begin
            pwr_r     <= ahpc_pkg::AHPC_PWR_ON;
            pwr_cnt_r <= '0;
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 1'b1;
          end
        end
        default: begin
          pwr_r     <= ahpc_pkg::AHPC_PWR_ON;
          pwr_cnt_r <= '0;
        end
      endcase
    end
  end

  // Analog comes up at the start of wake so its settling overlaps the delay.
  assign analog_on_out      = (pwr_r == ahpc_pkg::AHPC_PWR_ON) ||
                              (pwr_r == ahpc_pkg::AHPC_PWR_WAKE);
  assign ref_current_on_out = (pwr_r != ahpc_pkg::AHPC_PWR_SOFT);
  assign io_on_out          = 1'b1;
  assign conv_ready_out     = (pwr_r == ahpc_pkg::AHPC_PWR_ON);

  // ----------------------------------------------------------------
  // Conversion start and offset correction
  // ----------------------------------------------------------------
  logic       cal_pending_r;
  logic [9:0] offset_r;
  logic signed [11:0] corrected;
  logic [9:0] clamped;
  logic [9:0] formatted;
  logic       fifo_in_ready;

  // Samples are refused while powered down or while the FIFO is full.
  assign sample_start_out = conv_ready_out && fifo_in_ready &&
                            (trig_is_ext ? trig_fall : rd_fall);

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cal_pending_r <= 1'b0;
    end else if (!cal_mode) begin
      cal_pending_r <= 1'b0;
    end else if (rd_fall && conv_ready_out) begin
      cal_pending_r <= 1'b1;
    end else if (raw_valid_in) begin
      cal_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      offset_r <= ahpc_pkg::MID_CODE;
    end else if (cal_pending_r && raw_valid_in) begin
      offset_r <= raw_code_in;
    end
  end

  // Offset is held relative to mid-scale, so the correction is zero at 512.
  always_comb begin
    corrected = 12'(signed'({2'b00, raw_code_in})) -
                12'(signed'({2'b00, offset_r})) +
                12'(signed'({2'b00, ahpc_pkg::MID_CODE}));
    if (cal_mode) begin
      clamped = raw_code_in;
    end else if (corrected > 12'(signed'({2'b00, ahpc_pkg::CODE_MAX}))) begin
      clamped = ahpc_pkg::CODE_MAX;
    end else if (corrected < 12'(signed'({2'b00, ahpc_pkg::CODE_MIN}))) begin
      clamped = (offset_r > ahpc_pkg::MID_CODE) ? ahpc_pkg::CODE_MIN
                                                : ahpc_pkg::CODE_ZERO;
    end else begin
      clamped = corrected[9:0];
    end
    // Differential codes are offset-binary; inverting the top bit gives signed form.
    if (differential_in && cr1_r[ahpc_pkg::CR1_FMT_BIT]) begin
      formatted = {~clamped[9], clamped[8:0]};
    end else begin
      formatted = clamped;
    end
  end

  // ----------------------------------------------------------------
  // Result FIFO and host read
  // ----------------------------------------------------------------
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [9:0] fifo_data;
  logic [9:0] data_r;
  logic       oe_r;
  logic       int_n_r;

  ahpc_fifo #(
    .WIDTH (ahpc_pkg::DATA_W),
    .DEPTH (ahpc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (raw_valid_in),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (formatted),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  assign fifo_pop = rd_rise && oe_r;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      data_r  <= '0;
      oe_r    <= 1'b0;
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= !(fifo_out_valid && !fifo_pop);
      if (rd_rise) begin
        oe_r <= 1'b0;
      end else if (!rd_n_in && !cs_n_in && fifo_out_valid) begin
        oe_r   <= 1'b1;
        data_r <= fifo_data;
      end
    end
  end

  assign data_out    = data_r;
  assign data_oe_out = oe_r;
  assign int_n_out   = int_n_r;
endmodule
`default_nettype wire

// File: dv/ahpc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ahpc_ctrl_chk (
  // Clock and reset
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  // Host side
  input wire logic       cs_n_in,
  input wire logic       rd_n_in,
  input wire logic       wr_n_in,
  input wire logic       conv_trigger_n_in,
  input wire logic [9:0] data_in,
  input wire logic [9:0] data_out,
  input wire logic       data_oe_out,
  input wire logic       int_n_out,
  // Core and status
  input wire logic       differential_in,
  input wire logic [9:0] raw_code_in,
  input wire logic       raw_valid_in,
  input wire logic       sample_start_out,
  input wire logic       short_to_mid_out,
  input wire logic       analog_on_out,
  input wire logic       ref_current_on_out,
  input wire logic       io_on_out,
  input wire logic       conv_ready_out,
  input wire logic [7:0] control_reg_zero_out,
  input wire logic [7:0] control_reg_one_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  property p_start;
    sample_start_out |-> conv_ready_out && (control_reg_zero_out[1] ?
      $fell(conv_trigger_n_in) : ($fell(rd_n_in) && !cs_n_in));
  endproperty
  a_start: assert property (p_start) else $error("sample start without cause");
  property p_oe_pop;
    $rose(rd_n_in) && data_oe_out |=> !data_oe_out;
  endproperty
  a_oe_pop: assert property (p_oe_pop) else $error("bus not released");
  property p_int_push;
    raw_valid_in && rd_n_in && $past(rd_n_in) |-> ##2 !int_n_out;
  endproperty
  a_int_push: assert property (p_int_push) else $error("result not flagged");
  property p_soft_in;
    control_reg_one_out[0] && $rose(cs_n_in) ##1 cs_n_in [*5] |=>
      !analog_on_out && !ref_current_on_out;
  endproperty
  a_soft_in: assert property (p_soft_in) else $error("soft power-down missed");
  property p_io_alive;
    io_on_out;
  endproperty
  a_io_alive: assert property (p_io_alive) else $error("io buffers off");
  property p_auto_off;
    $fell(int_n_out) && control_reg_zero_out[4] |-> ##[0:1] !analog_on_out && ref_current_on_out;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto power-down wrong");
  property p_cfg_hold;
    !analog_on_out && wr_n_in && $past(wr_n_in) && $past(wr_n_in, 2) |=>
      $stable(control_reg_zero_out) && $stable(control_reg_one_out);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
  property p_soft_wake;
    $fell(control_reg_one_out[0]) && !$past(ref_current_on_out) |->
      ##18 !conv_ready_out ##[1:8] conv_ready_out;
  endproperty
  a_soft_wake: assert property (p_soft_wake) else $error("soft wake timing");
  property p_auto_wake;
    $fell(cs_n_in) && !analog_on_out && ref_current_on_out && !control_reg_zero_out[1] |=>
      !conv_ready_out [*8] ##[4:8] conv_ready_out;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("auto wake timing");
  property p_short_mid;
    $stable(control_reg_zero_out) |-> short_to_mid_out == (control_reg_zero_out[7:6] == 2'h2);
  endproperty
  a_short_mid: assert property (p_short_mid) else $error("mid short wrong");
  c_soft: cover property (!ref_current_on_out);
  c_auto: cover property (!analog_on_out && ref_current_on_out);
  c_cal: cover property (short_to_mid_out && raw_valid_in);
endmodule
`default_nettype wire

// File: dv/ahpc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahpc_core_model (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  // Request and answer
  input  wire logic       sample_start_in,
  input  wire logic [9:0] code_in,
  input  wire logic [3:0] delay_in,
  output logic            raw_valid_out,
  output logic      [9:0] raw_code_out
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [9:0] code_r;
  // Outside the valid cycle the code toggles so a late sample is never read as good.
  always_ff @(posedge ref_clk_in) begin
    raw_valid_out <= 1'b0;
    raw_code_out <= ~raw_code_out;
    if (!rstn_in) begin
      busy_r <= 1'b0;
      raw_code_out <= 10'h155;
    end else if (sample_start_in) begin
      busy_r <= 1'b1;
      cnt_r <= delay_in;
      code_r <= code_in;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      raw_valid_out <= 1'b1;
      raw_code_out <= code_r;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: dv/ahpc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ahpc_ctrl_bench;
  // ----
  // Stimulus and observation
  // ----
  logic ref_clk_in = 1'b0, rstn_in = 1'b0, cs_n_in = 1'b1, rd_n_in = 1'b1, wr_n_in = 1'b1;
  logic conv_trigger_n_in = 1'b1, differential_in = 1'b0;
  logic [9:0] data_in = 10'h000, code = 10'h000, q;
  logic [3:0] dly = 4'h2;
  logic [9:0] data_out, raw_code_in;
  logic [7:0] control_reg_zero_out, control_reg_one_out;
  logic data_oe_out, int_n_out, raw_valid_in, sample_start_out, short_to_mid_out;
  logic analog_on_out, ref_current_on_out, io_on_out, conv_ready_out;
  int failures = 0, samples_checked = 0, cycles = 0, starts = 0, n0;
  wire [9:0] pwr = {7'h000, analog_on_out, ref_current_on_out, io_on_out};
  ahpc_ctrl u_ahpc_ctrl (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
    .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .conv_trigger_n_in(conv_trigger_n_in),
    .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out), .int_n_out(int_n_out),
    .differential_in(differential_in), .raw_code_in(raw_code_in), .raw_valid_in(raw_valid_in),
    .sample_start_out(sample_start_out), .short_to_mid_out(short_to_mid_out),
    .analog_on_out(analog_on_out), .ref_current_on_out(ref_current_on_out),
    .io_on_out(io_on_out), .conv_ready_out(conv_ready_out),
    .control_reg_zero_out(control_reg_zero_out), .control_reg_one_out(control_reg_one_out));
  ahpc_core_model u_ahpc_core_model (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .sample_start_in(sample_start_out), .code_in(code), .delay_in(dly),
    .raw_valid_out(raw_valid_in), .raw_code_out(raw_code_in));
  always #25 ref_clk_in = ~ref_clk_in;
  // A hang anywhere still reaches the verdict through the cycle ceiling.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (rstn_in && sample_start_out === 1'b1) starts++;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end
  // ----
  // Checking and host access tasks
  // ----
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] d);
    @(posedge ref_clk_in);
    cs_n_in <= 1'b0;
    wr_n_in <= 1'b0;
    data_in <= d;
    @(posedge ref_clk_in);
    wr_n_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic rd_read(output logic [9:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    cs_n_in <= 1'b0;
    rd_n_in <= 1'b0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (data_oe_out !== 1'b1 && n < 60);
    r = data_out;
    @(posedge ref_clk_in);
    rd_n_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    check("bus released", {9'h000, data_oe_out}, 10'h000);
  endtask
  task automatic conv(input logic [9:0] raw, input logic [9:0] exp);
    code <= raw;
    rd_read(q);
    check("conversion", q, exp);
  endtask
  task automatic trig(input logic [9:0] raw);
    code <= raw;
    @(posedge ref_clk_in);
    conv_trigger_n_in <= 1'b0;
    @(posedge ref_clk_in);
    conv_trigger_n_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
  endtask
  // ----
  // Test sequence
  // ----
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    check("reset power", {pwr[8:0], conv_ready_out}, 10'h00F);
    check("reset int", {8'h00, int_n_out, data_oe_out}, 10'h002);
    wr(10'h204);
    differential_in <= 1'b1;
    conv(10'h100, 10'h300);
    conv(10'h3FF, 10'h1FF);
    differential_in <= 1'b0;
    conv(10'h3FF, 10'h3FF);
    wr(10'h200);
    wr(10'h080);
    check("internal short", {9'h000, short_to_mid_out}, 10'h001);
    dly <= 4'h9;
    conv(10'h210, 10'h210);
    wr(10'h000);
    conv(10'h3FF, 10'h3EF);
    conv(10'h210, 10'h200);
    conv(10'h008, 10'h001);
    wr(10'h040);
    check("system short", {9'h000, short_to_mid_out}, 10'h000);
    conv(10'h1F0, 10'h1F0);
    wr(10'h0C0);
    conv(10'h3FF, 10'h3FF);
    conv(10'h1F0, 10'h200);
    wr(10'h201);
    check("control one", {2'h0, control_reg_one_out}, 10'h001);
    check("before cs rise", pwr, 10'h007);
    @(posedge ref_clk_in);
    cs_n_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    #1;
    check("soft power", pwr, 10'h001);
    check("config kept", {2'h0, control_reg_zero_out}, 10'h0C0);
    wr(10'h200);
    check("wake wait", {9'h000, conv_ready_out}, 10'h000);
    repeat (24) @(posedge ref_clk_in);
    #1;
    check("awake", pwr, 10'h007);
    conv(10'h300, 10'h310);
    // Prompt answers and no reads let the buffer fill until it refuses.
    wr(10'h002);
    dly <= 4'h0;
    n0 = starts;
    for (int i = 0; i < 5; i++) trig(10'h101 + 10'(i));
    check("accepted starts", 10'(starts - n0), 10'h004);
    check("result waiting", {9'h000, int_n_out}, 10'h000);
    for (int i = 0; i < 4; i++) begin
      rd_read(q);
      check("buffered word", q, 10'h111 + 10'(i));
    end
    @(posedge ref_clk_in);
    #1;
    check("drained", {9'h000, int_n_out}, 10'h001);
    wr(10'h010);
    conv(10'h250, 10'h260);
    check("auto power", pwr, 10'h003);
    check("auto config", {2'h0, control_reg_zero_out}, 10'h010);
    @(posedge ref_clk_in);
    cs_n_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    cs_n_in <= 1'b0;
    repeat (17) @(posedge ref_clk_in);
    #1;
    check("auto resume", pwr, 10'h007);
    conv(10'h1F0, 10'h200);
    test_done();
  end
endmodule
bind ahpc_ctrl ahpc_ctrl_chk u_ahpc_ctrl_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
  .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
  .conv_trigger_n_in(conv_trigger_n_in), .data_in(data_in), .data_out(data_out),
  .data_oe_out(data_oe_out), .int_n_out(int_n_out), .differential_in(differential_in),
  .raw_code_in(raw_code_in), .raw_valid_in(raw_valid_in), .sample_start_out(sample_start_out),
  .short_to_mid_out(short_to_mid_out), .analog_on_out(analog_on_out),
  .ref_current_on_out(ref_current_on_out), .io_on_out(io_on_out),
  .conv_ready_out(conv_ready_out), .control_reg_zero_out(control_reg_zero_out),
  .control_reg_one_out(control_reg_one_out));
`default_nettype wire
